// ---- design/rrs_event_bank.v ----
// sticky event flags, interrupt enables and the interrupt line
`default_nettype none
`include "rrs_regs.vh"

module rrs_event_bank #(
   parameter N = `RRS_EVT_COUNT
) (
   input wire clk, // system clock
   input wire reset_n, // async reset, active low
   input wire ce, // clock enable, freezes all state
   input wire [N-1:0] event_pulse, // one-cycle event strobes
   input wire set_en_wr, // write to enable-set register
   input wire clr_en_wr, // write to enable-clear register
   input wire clr_stat_wr, // write to status register
   input wire [N-1:0] wdata, // write data, ones act
   output reg [N-1:0] enable_q, // interrupt enables
   output reg [N-1:0] status_q, // sticky event flags
   output reg irq_q // level interrupt
);

   // ***************************************************
   // state
   // ***************************************************
   reg [N-1:0] enable_d;
   reg [N-1:0] status_d;

   // a one disables, a one enables; clear wins when both in one word
   always @* begin
      enable_d = enable_q;
      if (set_en_wr)
         enable_d = enable_d | wdata;
      if (clr_en_wr)
         enable_d = enable_d & ~wdata; // RL1 RL2
      // new event beats a clear in the same cycle so it is never lost
      status_d = status_q;
      if (clr_stat_wr)
         status_d = status_d & ~wdata;
      status_d = status_d | event_pulse;
   end

   // flags and line are frozen while ce is low
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         enable_q <= {N{1'b0}};
         status_q <= {N{1'b0}};
         irq_q <= 1'b0;
      end else if (ce) begin
         enable_q <= enable_d;
         status_q <= status_d;
         irq_q <= |(status_d & enable_d);
      end
   end

endmodule // rrs_event_bank
`default_nettype wire

// ---- design/rrs_radio_regs.v ----
// rx status register bank of the packet radio, classic wishbone slave
//
// What this block does
// [RL1] writing one to an interrupt-disable bit clears it; reads show enable
// [RL2] disable bits for rx-ready, header, preamble, phy-end, tone-extension
// [RL3] preamble event only in the long-range or 250k modes while receiving
// [RL4] crc result reads one for a good crc, zero for an error
// [RL5] logical address of the previous packet is readable
// [RL6] crc field of the previous packet is readable
// [RL7] index of the device address pair that matched is readable
// [RL8] payload status reads one when length exceeds the configured maximum
// [RL9] long-range rate reads zero for 125 kbps, one for 500 kbps
// [RL10] tone extension time, reserved bit and type from extension byte
// [RL11] antenna switching state, codes zero idle to five ending
// [RL12] sampling state, zero idle and one sampling
// [RL13] packet pointer is the dma address for the next transaction
// [RL14] frequency resets to 2, base 2400 or 2360 MHz by map bit
`default_nettype none
`include "rrs_regs.vh"

module rrs_radio_regs #(
   parameter AW = 12, // byte address width
   parameter LOG_W = 3, // logical address width
   parameter CRC_W = 24, // received crc width
   parameter IDX_W = 3, // device address index width
   parameter LEN_W = 8, // payload length width
   parameter SW_W = 3 // switching state width
) (
   input wire clk, // system clock, 20 MHz
   input wire reset_n, // async reset, active low
   input wire ce, // clock enable, low freezes all state
   // wishbone classic slave
   input wire cyc_i, // bus cycle
   input wire stb_i, // strobe
   input wire we_i, // write enable
   input wire [AW-1:0] adr_i, // byte address
   input wire [3:0] sel_i, // byte lane selects
   input wire [31:0] dat_i, // write data
   output reg [31:0] dat_o, // read data
   output reg ack_o, // acknowledge
   output wire irq, // level interrupt
   // radio core events, one-cycle pulses
   input wire rx_ready_pulse, // receiver ramped up
   input wire hdr_match_pulse, // header matched
   input wire preamble_pulse, // possible preamble seen
   input wire phy_end_pulse, // last bit on air
   input wire tone_ext_pulse, // tone extension present
   input wire rx_active, // receive transaction running
   input wire [3:0] radio_mode, // current rate and modulation
   // received packet results
   input wire packet_done, // strobe: results below valid
   input wire crc_ok, // crc check passed
   input wire [LOG_W-1:0] rx_log_addr, // logical address received
   input wire [CRC_W-1:0] rx_crc, // crc field received
   input wire [IDX_W-1:0] match_idx, // matching address pair
   input wire [LEN_W-1:0] payload_len, // received payload length
   input wire [LEN_W-1:0] max_payload_length, // configured maximum
   input wire [1:0] long_range_rate, // long-range rate status
   input wire [7:0] tone_ext_byte, // extension info byte
   // direction finding machines
   input wire [SW_W-1:0] antenna_switching_state, // 0 idle .. 5 ending
   input wire sampling_state_a, // 0 idle, 1 sampling
   // packet dma
   input wire trans_start, // strobe: transaction begins
   output reg [31:0] dma_address, // address latched for transaction
   // synthesiser
   output reg [11:0] rf_frequency_mhz, // carrier in MHz
   output wire [`RRS_FREQ_CHAN_W-1:0] channel_value // channel field
);

   // ***************************************************
   // helpers
   // ***************************************************

   // widen byte selects to a bit mask
   function [31:0] lane_mask;
      input [3:0] sel;
      begin
         lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      end
   endfunction

   // merge write data into a register under the byte lanes
   function [31:0] lane_merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0] sel;
      begin
         lane_merge = (old & ~lane_mask(sel)) | (wd & lane_mask(sel));
      end
   endfunction

   // mhz of a channel under the chosen map
   function [11:0] chan_mhz;
      input [`RRS_FREQ_CHAN_W-1:0] chan;
      input low_map;
      begin
         chan_mhz = (low_map ? `RRS_BASE_LOW_MHZ : `RRS_BASE_DEFAULT_MHZ)
            + {5'h00, chan};
      end
   endfunction

   // ***************************************************
   // bus decode
   // ***************************************************
   wire req;
   wire wr_now;
   wire [31:0] wmask;
   wire [31:0] wbits;

   // a write lands in the cycle ack is high, the edge the master takes it
   assign req = cyc_i & stb_i;
   assign wr_now = req & we_i & ack_o;
   assign wmask = lane_mask(sel_i);
   assign wbits = dat_i & wmask;

   // ***************************************************
   // writable registers
   // ***************************************************
   reg [31:0] packet_ptr_q;
   reg [`RRS_FREQ_CHAN_W-1:0] chan_q;
   reg map_low_q;
   wire [31:0] freq_merged;

   assign freq_merged = lane_merge(
      {23'h0, map_low_q, 1'b0, chan_q}, dat_i, sel_i);
   assign channel_value = chan_q;

   // pointer and frequency written by software
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         packet_ptr_q <= `RRS_RST_PACKET_PTR;
         chan_q <= `RRS_RST_CHAN_FREQ; // RL14
         map_low_q <= 1'b0;
      end else if (ce && wr_now) begin
         if (adr_i == `RRS_OFS_PACKET_PTR)
            packet_ptr_q <= lane_merge(packet_ptr_q, dat_i, sel_i);
         if (adr_i == `RRS_OFS_CHAN_FREQ) begin
            chan_q <= freq_merged[`RRS_FREQ_CHAN_W-1:0];
            map_low_q <= freq_merged[`RRS_FREQ_MAP_BIT];
         end
      end
   end

   // dma address sampled at transaction start; later writes wait
   // for the next transaction so a packet never straddles two buffers
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         dma_address <= `RRS_RST_PACKET_PTR;
      else if (ce && trans_start)
         dma_address <= packet_ptr_q; // RL13
   end

   // synthesiser frequency follows the channel field and map
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         rf_frequency_mhz <= chan_mhz(`RRS_RST_CHAN_FREQ, 1'b0);
      else if (ce)
         rf_frequency_mhz <= chan_mhz(chan_q, map_low_q); // RL14
   end

   // ***************************************************
   // received packet status
   // ***************************************************
   reg crc_ok_q;
   reg [LOG_W-1:0] log_addr_q;
   reg [CRC_W-1:0] rx_crc_q;
   reg [IDX_W-1:0] match_idx_q;
   reg payload_over_q;
   reg [1:0] rate_q;
   reg [7:0] tone_byte_q;

   // results held from one packet until the next completes
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         crc_ok_q <= 1'b0;
         log_addr_q <= {LOG_W{1'b0}};
         rx_crc_q <= {CRC_W{1'b0}};
         match_idx_q <= {IDX_W{1'b0}};
         payload_over_q <= 1'b0;
         rate_q <= 2'b00;
         tone_byte_q <= 8'h00;
      end else if (ce && packet_done) begin
         crc_ok_q <= crc_ok; // RL4
         log_addr_q <= rx_log_addr; // RL5
         rx_crc_q <= rx_crc; // RL6
         match_idx_q <= match_idx; // RL7
         // equal length is not over the limit
         payload_over_q <= payload_len > max_payload_length; // RL8
         rate_q <= long_range_rate; // RL9
         tone_byte_q <= tone_ext_byte; // RL10
      end
   end

   // ***************************************************
   // direction finding state mirror
   // ***************************************************
   reg [SW_W-1:0] switch_q;
   reg sampling_q;

   // registered copy so a read sees one consistent snapshot
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         switch_q <= {SW_W{1'b0}};
         sampling_q <= 1'b0;
      end else if (ce) begin
         switch_q <= antenna_switching_state; // RL11
         sampling_q <= sampling_state_a; // RL12
      end
   end

   // ***************************************************
   // events and interrupts
   // ***************************************************
   wire lr_mode;
   wire [`RRS_EVT_COUNT-1:0] events;
   wire [`RRS_EVT_COUNT-1:0] enable;
   wire [`RRS_EVT_COUNT-1:0] status;
   wire set_en_wr;
   wire clr_en_wr;
   wire clr_stat_wr;

   // preamble hits outside the sync modes are ignored; hits inside may be
   // spurious, software must confirm with the later header event
   assign lr_mode = (radio_mode == `RRS_MODE_LR125K)
      || (radio_mode == `RRS_MODE_LR500K)
      || (radio_mode == `RRS_MODE_LR250K);
   assign events[`RRS_EVT_RX_READY] = rx_ready_pulse;
   assign events[`RRS_EVT_HDR_MATCH] = hdr_match_pulse;
   assign events[`RRS_EVT_PREAMBLE_SYNC] = preamble_pulse & rx_active
      & lr_mode; // RL3
   assign events[`RRS_EVT_PHY_END] = phy_end_pulse;
   assign events[`RRS_EVT_TONE_EXT] = tone_ext_pulse;

   // write strobes into the event bank
   assign set_en_wr = wr_now && (adr_i == `RRS_OFS_INT_ENSET);
   assign clr_en_wr = wr_now && (adr_i == `RRS_OFS_INT_ENCLR); // RL1
   assign clr_stat_wr = wr_now && (adr_i == `RRS_OFS_EVT_STATUS);

   rrs_event_bank #(
      .N(`RRS_EVT_COUNT)
   ) u_events (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .event_pulse(events),
      .set_en_wr(set_en_wr),
      .clr_en_wr(clr_en_wr),
      .clr_stat_wr(clr_stat_wr),
      .wdata(wbits[`RRS_EVT_COUNT-1:0]),
      .enable_q(enable), // RL2
      .status_q(status),
      .irq_q(irq)
   );

   // ***************************************************
   // read mux
   // ***************************************************
   reg [31:0] rdata;

   // unmapped addresses read zero and are still acknowledged
   always @* begin
      rdata = 32'h00000000;
      case (adr_i)
         `RRS_OFS_EVT_STATUS:
            rdata[`RRS_EVT_COUNT-1:0] = status;
         `RRS_OFS_INT_ENSET,
         `RRS_OFS_INT_ENCLR:
            rdata[`RRS_EVT_COUNT-1:0] = enable; // RL1
         `RRS_OFS_CRC_RESULT:
            rdata[0] = crc_ok_q; // RL4
         `RRS_OFS_RX_LOG_ADDR:
            rdata[LOG_W-1:0] = log_addr_q; // RL5
         `RRS_OFS_RX_CRC_VAL:
            rdata[CRC_W-1:0] = rx_crc_q; // RL6
         `RRS_OFS_ADDR_MATCH_IDX:
            rdata[IDX_W-1:0] = match_idx_q; // RL7
         `RRS_OFS_PAYLOAD_STATUS: begin
            rdata[`RRS_PAYLOAD_OVER_BIT] = payload_over_q; // RL8
            rdata[`RRS_RATE_LSB+`RRS_RATE_W-1:`RRS_RATE_LSB] = rate_q; // RL9
         end
         `RRS_OFS_TONE_EXT_INFO: begin
            rdata[`RRS_TONE_TIME_W-1:0] =
               tone_byte_q[`RRS_TONE_TIME_W-1:0]; // RL10
            rdata[`RRS_TONE_RSV_BIT] = tone_byte_q[`RRS_TONE_RSV_BIT];
            rdata[`RRS_TONE_TYPE_LSB+1:`RRS_TONE_TYPE_LSB] =
               tone_byte_q[`RRS_TONE_TYPE_LSB+1:`RRS_TONE_TYPE_LSB];
         end
         `RRS_OFS_DF_STATE: begin
            rdata[SW_W-1:0] = switch_q; // RL11
            rdata[`RRS_SAMPLING_BIT] = sampling_q; // RL12
         end
         `RRS_OFS_PACKET_PTR:
            rdata = packet_ptr_q; // RL13
         `RRS_OFS_CHAN_FREQ: begin
            rdata[`RRS_FREQ_CHAN_W-1:0] = chan_q;
            rdata[`RRS_FREQ_MAP_BIT] = map_low_q;
         end
         default:
            rdata = 32'h00000000;
      endcase
   end

   // ***************************************************
   // acknowledge
   // ***************************************************

   // one wait state: ack the cycle after the request, drop it after
   // one cycle so a back-to-back request is never acked twice
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else if (ce) begin
         ack_o <= req & ~ack_o;
         if (req & ~ack_o & ~we_i)
            dat_o <= rdata;
      end
   end

endmodule // rrs_radio_regs
`default_nettype wire

// ---- design/rrs_regs.vh ----
// register map, field positions and reset values of the rx status bank
`ifndef RRS_REGS_VH
`define RRS_REGS_VH

// ***************************************************
// register byte offsets
// ***************************************************
`define RRS_OFS_EVT_STATUS 12'h100
`define RRS_OFS_INT_ENSET 12'h304
`define RRS_OFS_INT_ENCLR 12'h308
`define RRS_OFS_CRC_RESULT 12'h400
`define RRS_OFS_RX_LOG_ADDR 12'h408
`define RRS_OFS_RX_CRC_VAL 12'h40c
`define RRS_OFS_ADDR_MATCH_IDX 12'h410
`define RRS_OFS_PAYLOAD_STATUS 12'h414
`define RRS_OFS_TONE_EXT_INFO 12'h44c
`define RRS_OFS_DF_STATE 12'h458
`define RRS_OFS_PACKET_PTR 12'h504
`define RRS_OFS_CHAN_FREQ 12'h508

// ***************************************************
// event bit positions in status, enable set and enable clear
// ***************************************************
`define RRS_EVT_RX_READY 0
`define RRS_EVT_HDR_MATCH 1
`define RRS_EVT_PREAMBLE_SYNC 2
`define RRS_EVT_PHY_END 3
`define RRS_EVT_TONE_EXT 4
`define RRS_EVT_COUNT 5

// ***************************************************
// field positions
// ***************************************************
`define RRS_PAYLOAD_OVER_BIT 0
`define RRS_RATE_LSB 1
`define RRS_RATE_W 2
`define RRS_TONE_TIME_W 5
`define RRS_TONE_RSV_BIT 5
`define RRS_TONE_TYPE_LSB 6
`define RRS_SAMPLING_BIT 4
`define RRS_FREQ_CHAN_W 7
`define RRS_FREQ_MAP_BIT 8

// ***************************************************
// reset values and radio constants
// ***************************************************
`define RRS_RST_PACKET_PTR 32'h00000000
`define RRS_RST_CHAN_FREQ 7'h02
`define RRS_BASE_DEFAULT_MHZ 12'h960
`define RRS_BASE_LOW_MHZ 12'h938
`define RRS_MODE_LR125K 4'h5
`define RRS_MODE_LR500K 4'h6
`define RRS_MODE_LR250K 4'hf

`endif

// ---- tb/rrs_radio_regs_sva.sv ----
// assertion checker for the rx status register bank ports
`default_nettype none
module rrs_radio_regs_sva (
   input wire logic clk, // system clock
   input wire logic reset_n, // async reset, active low
   input wire logic ce, // clock enable
   input wire logic cyc_i, // bus cycle
   input wire logic stb_i, // strobe
   input wire logic we_i, // write enable
   input wire logic [31:0] dat_o, // read data
   input wire logic ack_o, // acknowledge
   input wire logic irq, // level interrupt
   input wire logic trans_start, // transaction begins
   input wire logic [31:0] dma_address, // latched dma address
   input wire logic [11:0] rf_frequency_mhz, // carrier in mhz
   input wire logic [6:0] channel_value // channel field
);
   timeunit 1ns;
   timeprecision 1ns;
   // ***************************************************
   // bus handshake and register side effects
   // ***************************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_ack_one_wait: assert property ((cyc_i && stb_i && !ack_o && ce) |=> ack_o)
      else $error("no ack one cycle after request");
   a_ack_one_cycle: assert property ((ack_o && ce) |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_needs_req: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   a_read_data_hold: assert property ($changed(dat_o) |-> ack_o)
      else $error("read data moved outside an ack");
   // irq only drops after a write has cleared status or enable
   a_irq_fall_cause: assert property ($fell(irq) |-> $past(we_i && ack_o) ||
      $past(we_i && ack_o, 2) || $past(we_i && ack_o, 3))
      else $error("irq dropped without a write");
   a_dma_hold: assert property (!trans_start |=> $stable(dma_address))
      else $error("dma address moved without a start");
   // two stable samples let the registered carrier catch up
   a_freq_map_base: assert property ($stable(channel_value) [*2] |->
      (rf_frequency_mhz == 12'h960 + channel_value ||
      rf_frequency_mhz == 12'h938 + channel_value))
      else $error("carrier does not match channel");
   a_reset_freq: assert property ($rose(reset_n) |->
      rf_frequency_mhz == 12'h962 && channel_value == 7'h02)
      else $error("frequency reset value wrong");
   c_write: cover property (ack_o && we_i);
   c_irq: cover property ($rose(irq));
   c_trans: cover property (trans_start ##1 $changed(dma_address));
endmodule // rrs_radio_regs_sva
`default_nettype wire

// ---- tb/tb_rrs_radio_regs.sv ----
// self-checking bench for the rx status register bank
`default_nettype none
module tb_rrs_radio_regs;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, reset_n, cyc, stb, we, irq, ack, pkt, crc_ok, rx_act;
   logic trans, samp, ce;
   logic [3:0] sel, lanes;
   logic [11:0] adr, rf_mhz;
   logic [31:0] wd, rd, dma, r;
   logic [4:0] ev;
   logic [3:0] mode;
   logic [2:0] log_a, idx, sw;
   logic [23:0] crc;
   logic [7:0] len, maxl, tone;
   logic [1:0] rate;
   logic [6:0] chan;
   logic [31:0] exp_q[$];
   logic [11:0] ofs[8] = '{12'h400, 12'h408, 12'h40c, 12'h410, 12'h414,
      12'h44c, 12'h458, 12'h504};
   logic [3:0] md[4] = '{4'h5, 4'h6, 4'hf, 4'h3};
   int num_errors = 0;
   int total_checks = 0;

   rrs_radio_regs dut_u (.clk(clk), .reset_n(reset_n), .ce(ce),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
      .dat_i(wd), .dat_o(rd), .ack_o(ack), .irq(irq),
      .rx_ready_pulse(ev[0]), .hdr_match_pulse(ev[1]),
      .preamble_pulse(ev[2]), .phy_end_pulse(ev[3]),
      .tone_ext_pulse(ev[4]), .rx_active(rx_act), .radio_mode(mode),
      .packet_done(pkt), .crc_ok(crc_ok), .rx_log_addr(log_a),
      .rx_crc(crc), .match_idx(idx), .payload_len(len),
      .max_payload_length(maxl), .long_range_rate(rate),
      .tone_ext_byte(tone), .antenna_switching_state(sw),
      .sampling_state_a(samp), .trans_start(trans), .dma_address(dma),
      .rf_frequency_mhz(rf_mhz), .channel_value(chan));

   // 20 mhz system clock
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end

   // ***************************************************
   // shared tasks
   // ***************************************************
   task automatic fail(input string m);
      num_errors++;
      $display("unexpected at %0t: %s", $time, m);
   endtask
   task automatic chk(input logic [31:0] g, e, input string m);
      total_checks++;
      if (g !== e) fail(m);
   endtask
   // classic cycle; for reads d is the expected word, queued for the monitor
   task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      sel <= lanes;
      adr <= a;
      wd <= d;
      if (!w) exp_q.push_back(d);
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) fail("no acknowledge");
      cyc <= 0;
      stb <= 0;
   endtask
   // one-cycle event strobes, then time for status and irq to settle
   task automatic pulse(input logic [4:0] v);
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= '0;
      repeat (3) @(posedge clk);
   endtask
   // random packet results, payload equal to the maximum when eq is set
   task automatic packet(input logic eq);
      r = $urandom;
      @(posedge clk);
      {crc_ok, log_a, idx} <= r[6:0];
      crc <= r[31:8];
      rate <= {1'b0, r[7]};
      tone <= r[15:8];
      len <= r[23:16];
      maxl <= eq ? r[23:16] : r[31:24];
      pkt <= 1;
      @(posedge clk);
      pkt <= 0;
      bus(0, 12'h400, {31'h0, crc_ok});
      bus(0, 12'h408, {29'h0, log_a});
      bus(0, 12'h40c, {8'h0, crc});
      bus(0, 12'h410, {29'h0, idx});
      bus(0, 12'h414, {29'h0, rate, len > maxl});
      bus(0, 12'h44c, {24'h0, tone});
   endtask
   task automatic tally_and_finish;
      if (exp_q.size() != 0) fail("reads never answered");
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // monitor: each read ack takes the oldest queued note
   always @(posedge clk) begin
      if (ack === 1'b1 && we === 1'b0) begin
         if (exp_q.size() == 0) fail("read without note");
         else chk(rd, exp_q.pop_front(), "read data");
      end
   end

   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #1000000;
      fail("watchdog expired");
      tally_and_finish();
   end

   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      reset_n = 0;
      {cyc, stb, we, pkt, crc_ok, rx_act, trans, samp, ev, mode} = '0;
      {adr, wd, log_a, idx, sw, crc, len, maxl, tone, rate} = '0;
      ce = 1;
      sel = 4'hf;
      lanes = 4'hf;
      void'($urandom(47));
      repeat (2) @(posedge clk);
      reset_n <= 1;
      chk(rf_mhz, 12'h962, "reset carrier");
      foreach (ofs[i]) bus(0, ofs[i], 32'h0);
      bus(0, 12'h508, 32'h2);
      bus(0, 12'h7f0, 32'h0);
      $display("test reset values done");
      for (int k = 0; k < 4; k++) packet(k[0]);
      bus(1, 12'h414, 32'hffffffff);
      bus(0, 12'h414, {29'h0, rate, len > maxl});
      $display("test packet results done");
      for (int k = 0; k < 6; k++) begin
         @(posedge clk);
         sw <= k[2:0];
         samp <= k[0];
         bus(0, 12'h458, {27'h0, k[0], 1'b0, k[2:0]});
      end
      $display("test direction finding done");
      rx_act <= 1;
      mode <= 4'h5;
      bus(1, 12'h304, 32'h1f);
      bus(0, 12'h308, 32'h1f);
      pulse(5'h1f);
      bus(0, 12'h100, 32'h1f);
      chk(irq, 1, "irq not raised");
      for (int k = 0; k < 5; k++) begin
         bus(1, 12'h308, 32'h1 << k);
         bus(0, 12'h304, 32'h1e << k & 32'h1f);
      end
      repeat (3) @(posedge clk);
      chk(irq, 0, "irq while masked");
      bus(1, 12'h100, 32'h1f);
      bus(0, 12'h100, 32'h0);
      foreach (md[i]) begin
         mode <= md[i];
         pulse(5'h04);
         bus(0, 12'h100, {29'h0, md[i] != 4'h3, 2'h0});
         bus(1, 12'h100, 32'h4);
      end
      rx_act <= 0;
      mode <= 4'h5;
      pulse(5'h04);
      bus(0, 12'h100, 32'h0);
      bus(1, 12'h304, 32'h1);
      pulse(5'h01);
      chk(irq, 1, "irq not raised");
      bus(1, 12'h100, 32'h1);
      repeat (3) @(posedge clk);
      chk(irq, 0, "irq not cleared");
      // events arriving while the clock enable is low must be lost
      ce <= 0;
      pulse(5'h01);
      chk(irq, 0, "event taken while frozen");
      ce <= 1;
      bus(0, 12'h100, 32'h0);
      $display("test interrupts done");
      r = $urandom;
      bus(1, 12'h504, r);
      bus(0, 12'h504, r);
      @(posedge clk);
      trans <= 1;
      @(posedge clk);
      trans <= 0;
      @(posedge clk);
      chk(dma, r, "dma address");
      // only the selected low byte lane may change
      lanes = 4'h1;
      bus(1, 12'h504, ~r);
      lanes = 4'hf;
      bus(0, 12'h504, {r[31:8], ~r[7:0]});
      bus(1, 12'h508, 32'h105);
      bus(0, 12'h508, 32'h105);
      chk(rf_mhz, 12'h938 + 12'h5, "low map carrier");
      bus(1, 12'h508, 32'h7f);
      repeat (2) @(posedge clk);
      chk(rf_mhz, 12'h960 + 12'h7f, "default map carrier");
      chk(chan, 7'h7f, "channel field");
      $display("test pointer and frequency done");
      tally_and_finish();
   end
endmodule // tb_rrs_radio_regs

bind rrs_radio_regs rrs_radio_regs_sva chk_u (.clk(clk), .reset_n(reset_n),
   .ce(ce), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .dat_o(dat_o),
   .ack_o(ack_o), .irq(irq), .trans_start(trans_start),
   .dma_address(dma_address), .rf_frequency_mhz(rf_frequency_mhz),
   .channel_value(channel_value));
`default_nettype wire
